/* File: include/adc_measure_pkg.sv */
package adc_measure_pkg;

   // ==========================================================
   // Converter geometry and timing
   localparam int          CODE_W           = 8;
   localparam logic [7:0]  CODE_MIN         = 8'h00;
   localparam logic [7:0]  CODE_MAX         = 8'hff;
   localparam logic [7:0]  CODE_RESET       = 8'h00;
   // Conversion length in carrier periods
   localparam int          CONV_FC_PERIODS  = 224;
   // Crystal frequency in kHz, carrier is crystal divided by two
   localparam int          XTAL_KHZ         = 27120;
   localparam int          CARRIER_DIV      = 2;
   localparam int          CARRIER_KHZ      = XTAL_KHZ / CARRIER_DIV;
   // Conversion time in ns (224 periods of 13.56 MHz is about 16519 ns)
   localparam int          CONV_TIME_NS     = (CONV_FC_PERIODS * 1000000 + CARRIER_KHZ - 1)
                                              / CARRIER_KHZ;
   localparam int          CLK_PERIOD_NS    = 40;
   // Cycles of clk_i for one conversion, rounded up, at least one
   localparam int          CONV_CYCLES_RAW  = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int          CONV_CYCLES      = (CONV_CYCLES_RAW < 1) ? 1 : CONV_CYCLES_RAW;
   // Successive approximation: one bit per step, cycles per bit decision
   localparam int          BIT_CYCLES       = CONV_CYCLES / CODE_W;

   // ==========================================================
   // Input multiplexer sources
   typedef enum logic [1:0] {
      SRC_AMPLITUDE = 2'h0,
      SRC_PHASE     = 2'h1,
      SRC_AUX       = 2'h2
   } source_t;

   // Reference modes
   typedef enum logic {
      REF_ABSOLUTE = 1'b0,
      REF_RELATIVE = 1'b1
   } ref_mode_t;

   // Commands
   typedef enum logic [1:0] {
      CMD_NONE      = 2'h0,
      CMD_AMPLITUDE = 2'h1,
      CMD_PHASE     = 2'h2,
      CMD_AUX       = 2'h3
   } command_t;

   // Analog front end control, travels as one bundle
   typedef struct packed {
      source_t   source;
      ref_mode_t ref_mode;
      logic      sample;
   } afe_ctrl_t;

   // Converter result bundle
   typedef struct packed {
      logic [7:0] code;
      logic       done;
      logic       busy;
   } result_t;

endpackage : adc_measure_pkg

/* File: logic/carrier_divider.sv */
`timescale 1ns/10ps

// ==========================================================
// Crystal divide-by-two, gives 50 percent duty carrier
module carrier_divider
(
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic xtal_i,
   output logic      carrier_o
);

   logic xtal_q_ff;
   logic carrier_ff;
   logic nxt_xtal_q;
   logic nxt_carrier;

   // Toggle on each rising crystal edge seen in the sample
   always_comb
   begin
      nxt_xtal_q  = xtal_i;
      nxt_carrier = carrier_ff;
      if (xtal_i && !xtal_q_ff)
      begin
         nxt_carrier = ~carrier_ff;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         xtal_q_ff  <= 1'b0;
         carrier_ff <= 1'b0;
      end
      else
      begin
         xtal_q_ff  <= nxt_xtal_q;
         carrier_ff <= nxt_carrier;
      end
   end

   assign carrier_o = carrier_ff;

endmodule : carrier_divider

/* File: logic/phase_amplitude_adc_measure.sv */
`timescale 1ns/10ps


module phase_amplitude_adc_measure
#(
   parameter int CONV_CYCLES = adc_measure_pkg::CONV_CYCLES
)
(
   input  wire logic                          clk_i,
   input  wire logic                          reset_i,
   input  wire logic                          xtal_i,
   input  wire adc_measure_pkg::command_t     command_i,
   input  wire logic                          command_valid_i,
   input  wire logic                          compare_high_i,
   output adc_measure_pkg::afe_ctrl_t         afe_ctrl_o,
   output logic [7:0]                         trial_code_o,
   output adc_measure_pkg::result_t           result_o,
   output logic                               carrier_o
);

   // ==========================================================
   // State machine
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b001,
      ST_SETTLE = 3'b010,
      ST_CONV   = 3'b100
   } state_t;

   localparam int STEP_CYCLES = (CONV_CYCLES / adc_measure_pkg::CODE_W < 1) ? 1 :
                                CONV_CYCLES / adc_measure_pkg::CODE_W;
   localparam int SETTLE_CYCLES = CONV_CYCLES - STEP_CYCLES * adc_measure_pkg::CODE_W;
   localparam int CNT_W = $clog2(CONV_CYCLES + 1);

   state_t                        state_ff;
   state_t                        nxt_state;
   logic [CNT_W-1:0]              cnt_ff;
   logic [CNT_W-1:0]              nxt_cnt;
   logic [2:0]                    bit_ff;
   logic [2:0]                    nxt_bit;
   logic [7:0]                    trial_ff;
   logic [7:0]                    nxt_trial;
   logic [7:0]                    code_ff;
   logic [7:0]                    nxt_code;
   logic                          done_ff;
   logic                          nxt_done;
   adc_measure_pkg::afe_ctrl_t    ctrl_ff;
   adc_measure_pkg::afe_ctrl_t    nxt_ctrl;
   logic                          carrier;

   // ==========================================================
   // Carrier generation
   carrier_divider u_carrier_divider
   (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .xtal_i    (xtal_i),
      .carrier_o (carrier)
   );

   // ==========================================================
   // Command decode, conversion sequencing and result keeping
   always_comb
   begin
      nxt_state = state_ff;
      nxt_cnt   = cnt_ff;
      nxt_bit   = bit_ff;
      nxt_trial = trial_ff;
      nxt_code  = code_ff;
      nxt_done  = 1'b0;
      nxt_ctrl  = ctrl_ff;
      case (state_ff)
         ST_IDLE:
         begin
            nxt_ctrl.sample = 1'b0;
            // Commands while busy are dropped; the host must wait for done
            if (command_valid_i && command_i != adc_measure_pkg::CMD_NONE)
            begin
               case (command_i)
                  adc_measure_pkg::CMD_PHASE:
                  begin
                     nxt_ctrl.source   = adc_measure_pkg::SRC_PHASE;
                     nxt_ctrl.ref_mode = adc_measure_pkg::REF_RELATIVE;
                  end
                  adc_measure_pkg::CMD_AMPLITUDE:
                  begin
                     nxt_ctrl.source   = adc_measure_pkg::SRC_AMPLITUDE;
                     nxt_ctrl.ref_mode = adc_measure_pkg::REF_ABSOLUTE;
                  end
                  default:
                  begin
                     nxt_ctrl.source   = adc_measure_pkg::SRC_AUX;
                     nxt_ctrl.ref_mode = adc_measure_pkg::REF_ABSOLUTE;
                  end
               endcase
               nxt_ctrl.sample = 1'b1;
               nxt_cnt         = CNT_W'(SETTLE_CYCLES);
               nxt_state       = (SETTLE_CYCLES > 0) ? ST_SETTLE : ST_CONV;
               nxt_bit         = 3'h7;
               nxt_trial       = 8'h80;
               if (SETTLE_CYCLES == 0)
               begin
                  nxt_cnt = CNT_W'(STEP_CYCLES);
               end
            end
         end
         ST_SETTLE:
         begin
            // Absorbs the remainder so the total is exactly CONV_CYCLES
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == CNT_W'(1))
            begin
               nxt_cnt   = CNT_W'(STEP_CYCLES);
               nxt_state = ST_CONV;
            end
         end
         ST_CONV:
         begin
            nxt_cnt = cnt_ff - 1'b1;
            if (cnt_ff == CNT_W'(1))
            begin
               nxt_cnt = CNT_W'(STEP_CYCLES);
               // Keep trial bit when the input lies above the trial level
               nxt_trial = trial_ff;
               if (!compare_high_i)
               begin
                  nxt_trial[bit_ff] = 1'b0;
               end
               if (bit_ff == 3'h0)
               begin
                  // Comparator clamps give 00h below range and ffh above
                  nxt_code        = nxt_trial;
                  nxt_done        = 1'b1;
                  nxt_ctrl.sample = 1'b0;
                  nxt_state       = ST_IDLE;
               end
               else
               begin
                  nxt_bit            = bit_ff - 1'b1;
                  nxt_trial[nxt_bit] = 1'b1;
               end
            end
         end
         default:
         begin
            nxt_state = ST_IDLE;
         end
      endcase
   end

   // Registers
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_ff <= ST_IDLE;
         cnt_ff   <= '0;
         bit_ff   <= 3'h7;
         trial_ff <= 8'h00;
         code_ff  <= adc_measure_pkg::CODE_RESET;
         done_ff  <= 1'b0;
         ctrl_ff  <= '{source: adc_measure_pkg::SRC_AMPLITUDE,
                       ref_mode: adc_measure_pkg::REF_ABSOLUTE, sample: 1'b0};
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff   <= nxt_cnt;
         bit_ff   <= nxt_bit;
         trial_ff <= nxt_trial;
         code_ff  <= nxt_code;
         done_ff  <= nxt_done;
         ctrl_ff  <= nxt_ctrl;
      end
   end

   // ==========================================================
   // Outputs, all straight from flip-flops
   assign afe_ctrl_o    = ctrl_ff;
   assign trial_code_o  = trial_ff;
   assign result_o.code = code_ff;
   assign result_o.done = done_ff;
   assign result_o.busy = ctrl_ff.sample; // Host polls this low before reading
   assign carrier_o     = carrier;

endmodule : phase_amplitude_adc_measure

/* File: dv/adc_measure_chk_sva.sv */
`timescale 1ns/10ps

// ==========================================================
// Port checks for the measurement converter
module adc_measure_chk
#(
   parameter int CONV_CYCLES = adc_measure_pkg::CONV_CYCLES
)
(
   input wire logic                       clk_i,
   input wire logic                       reset_i,
   input wire logic                       xtal_i,
   input wire adc_measure_pkg::command_t  command_i,
   input wire logic                       command_valid_i,
   input wire logic                       compare_high_i,
   input wire adc_measure_pkg::afe_ctrl_t afe_ctrl_o,
   input wire logic [7:0]                 trial_code_o,
   input wire adc_measure_pkg::result_t   result_o,
   input wire logic                       carrier_o
);
   logic        take;
   logic [15:0] cnt_ff;
   logic [15:0] nxt_cnt;

   // Only idle requests count, so a refused one never restarts the count
   assign take = command_valid_i && command_i != adc_measure_pkg::CMD_NONE && !result_o.busy;

   // Cycles since the request was taken
   always_comb
   begin
      nxt_cnt = take ? 16'h1 : (result_o.busy ? cnt_ff + 16'h1 : cnt_ff);
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         cnt_ff <= 16'h0;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   AST_TAKE_BUSY: assert property (take |=> result_o.busy)
      else $error("request not taken");
   AST_BUSY_END: assert property ($fell(result_o.busy) |-> result_o.done)
      else $error("busy ended without done");
   AST_DONE_TIME: assert property (result_o.done |-> cnt_ff == CONV_CYCLES + 1)
      else $error("conversion length wrong");
   AST_DONE_PULSE: assert property (result_o.done |-> !result_o.busy && $past(result_o.busy) ##1 !result_o.done)
      else $error("done not a single pulse ending busy");
   AST_REF_PHASE: assert property (afe_ctrl_o.sample && afe_ctrl_o.source == 2'h1 |-> afe_ctrl_o.ref_mode)
      else $error("phase not in relative mode");
   AST_REF_ABS: assert property (afe_ctrl_o.sample && afe_ctrl_o.source != 2'h1 |-> !afe_ctrl_o.ref_mode)
      else $error("absolute mode missing");
   AST_SRC_CMD: assert property (take |=> afe_ctrl_o.source == $past(command_i) - 2'h1)
      else $error("wrong source routed");
   AST_TRIAL_START: assert property (take |=> trial_code_o == 8'h80)
      else $error("search does not start at mid code");
   AST_CODE_HOLD: assert property (!result_o.done |-> $stable(result_o.code))
      else $error("result changed between conversions");
   AST_DONE_CODE: assert property (result_o.done |-> result_o.code == trial_code_o)
      else $error("result differs from final trial");
endmodule : adc_measure_chk

bind phase_amplitude_adc_measure adc_measure_chk #(.CONV_CYCLES(CONV_CYCLES)) u_chk
(
   .clk_i(clk_i), .reset_i(reset_i), .xtal_i(xtal_i), .command_i(command_i),
   .command_valid_i(command_valid_i), .compare_high_i(compare_high_i),
   .afe_ctrl_o(afe_ctrl_o), .trial_code_o(trial_code_o), .result_o(result_o),
   .carrier_o(carrier_o)
);

/* File: dv/tb_phase_amplitude_adc_measure.sv */
`timescale 1ns/10ps

// ==========================================================
// Bench for the measurement converter
module tb_phase_amplitude_adc_measure;
   localparam int CONV = 24;
   logic                       clk_i = 1'b0;
   logic                       reset_i = 1'b1;
   logic                       xtal_i = 1'b0;
   adc_measure_pkg::command_t  command_i = adc_measure_pkg::CMD_NONE;
   logic                       command_valid_i = 1'b0;
   logic                       compare_high_i = 1'b0;
   adc_measure_pkg::afe_ctrl_t afe;
   logic [7:0]                 trial;
   adc_measure_pkg::result_t   res;
   logic                       carrier;
   logic                       carrier_q = 1'b0;
   logic [7:0]                 vin = 8'h00;
   int                         seed = 8;
   int                         num_errors = 0;
   int                         checked = 0;
   int                         toggles = 0;
   int                         n;

   phase_amplitude_adc_measure #(.CONV_CYCLES(CONV)) u_dut
   (
      .clk_i(clk_i), .reset_i(reset_i), .xtal_i(xtal_i), .command_i(command_i),
      .command_valid_i(command_valid_i), .compare_high_i(compare_high_i),
      .afe_ctrl_o(afe), .trial_code_o(trial), .result_o(res), .carrier_o(carrier)
   );

   // Clock
   initial
   begin
      forever #20 clk_i = ~clk_i;
   end

   // Ideal comparator, one cycle late, which a step of three cycles absorbs
   always @(posedge clk_i)
   begin
      compare_high_i <= (trial <= vin);
      xtal_i <= ($time % 240 < 120);
      if (!reset_i && carrier !== carrier_q)
      begin
         toggles++;
      end
      carrier_q <= carrier;
   end

   // ==========================================================
   // Expectations and comparisons
   function automatic adc_measure_pkg::afe_ctrl_t exp_ctrl(adc_measure_pkg::command_t c);
      // Each command has its own detector; only phase uses the relative references
      case (c)
         adc_measure_pkg::CMD_PHASE:
         begin
            exp_ctrl.source   = adc_measure_pkg::SRC_PHASE;
            exp_ctrl.ref_mode = adc_measure_pkg::REF_RELATIVE;
         end
         adc_measure_pkg::CMD_AMPLITUDE:
         begin
            exp_ctrl.source   = adc_measure_pkg::SRC_AMPLITUDE;
            exp_ctrl.ref_mode = adc_measure_pkg::REF_ABSOLUTE;
         end
         default:
         begin
            exp_ctrl.source   = adc_measure_pkg::SRC_AUX;
            exp_ctrl.ref_mode = adc_measure_pkg::REF_ABSOLUTE;
         end
      endcase
      exp_ctrl.sample = 1'b1;
   endfunction : exp_ctrl

   task automatic check_code(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp)
      begin
         num_errors++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask : check_code

   task automatic check_ctrl(input adc_measure_pkg::afe_ctrl_t got, exp);
      check_code({4'h0, got}, {4'h0, exp});
   endtask : check_ctrl

   task automatic wait_done();
      n = 1;
      while (res.done !== 1'b1 && n < 200)
      begin
         @(negedge clk_i);
         n++;
      end
   endtask : wait_done

   // One conversion with a given input level
   task automatic run_cmd(input adc_measure_pkg::command_t c, input logic [7:0] v);
      @(posedge clk_i);
      vin <= v;
      command_i <= c;
      command_valid_i <= 1'b1;
      @(posedge clk_i);
      command_valid_i <= 1'b0;
      @(negedge clk_i);
      check_ctrl(afe, exp_ctrl(c));
      wait_done();
      // Done shows CONV edges after the taking edge, n starts at one
      check_code(8'(n), 8'(CONV + 1));
      check_code(res.code, v);
   endtask : run_cmd

   task automatic stop_test();
      $display("errors %0d checks %0d", num_errors, checked);
      if (num_errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : stop_test

   // Watchdog
   initial
   begin
      // About seventeen conversions plus the carrier window, with ample margin
      repeat (40 * (CONV + 8)) @(posedge clk_i);
      num_errors++;
      $display("[FAIL] %0t watchdog expired", $time);
      stop_test();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      repeat (16) @(posedge clk_i);
      reset_i <= 1'b0;
      @(negedge clk_i);
      check_code(res.code, adc_measure_pkg::CODE_RESET);
      check_code(trial, 8'h00);
      check_ctrl(afe, 4'h0);
      // An empty command must not start anything
      @(posedge clk_i);
      command_valid_i <= 1'b1;
      @(posedge clk_i);
      command_valid_i <= 1'b0;
      @(negedge clk_i);
      check_code({7'h0, res.busy}, 8'h00);
      run_cmd(adc_measure_pkg::CMD_AMPLITUDE, 8'h00);
      run_cmd(adc_measure_pkg::CMD_PHASE, 8'hff);
      run_cmd(adc_measure_pkg::CMD_AUX, 8'h7f);
      repeat (12) run_cmd(adc_measure_pkg::command_t'(1 + $unsigned($random(seed)) % 3),
                          8'($random(seed)));
      // Held request: a change while busy is refused, the next is taken at done
      @(posedge clk_i);
      vin <= 8'h5a;
      command_i <= adc_measure_pkg::CMD_PHASE;
      command_valid_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      command_i <= adc_measure_pkg::CMD_AMPLITUDE;
      repeat (5) @(posedge clk_i);
      @(negedge clk_i);
      check_ctrl(afe, exp_ctrl(adc_measure_pkg::CMD_PHASE));
      wait_done();
      check_code(res.code, 8'h5a);
      @(negedge clk_i);
      check_ctrl(afe, exp_ctrl(adc_measure_pkg::CMD_AMPLITUDE));
      @(posedge clk_i);
      command_valid_i <= 1'b0;
      wait_done();
      check_code(res.code, 8'h5a);
      // Carrier halves the crystal rate
      toggles = 0;
      repeat (120) @(posedge clk_i);
      check_code(8'(toggles >= 19 && toggles <= 21), 8'h01);
      stop_test();
   end
endmodule : tb_phase_amplitude_adc_measure
